// ---- logic/rfs_closure_timer.sv ----
/*
  Closure timer for one terminal: synchronises the pin, counts consecutive
  closed samples and flags when the threshold is reached.
  Assumes the pin is asynchronous to clock.
*/
module rfs_closure_timer #(
  parameter int unsigned LIMIT = rfs_pkg::MIN_CLOSE_CYC
) (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      closed,
  output logic      held
);
  logic                     syncA;
  logic [rfs_pkg::CNT_W-1:0] count;

  // two stages before any logic reads the pin
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      syncA  <= 1'b0;
      closed <= 1'b0;
    end else begin
      syncA  <= pin;
      closed <= syncA;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || !closed) begin
      count <= '0;
      held  <= 1'b0;
    end else if (count < rfs_pkg::CNT_W'(LIMIT - 1)) begin
      count <= count + 1'b1;
    end else begin
      held <= 1'b1;
    end
  end
endmodule

// ---- logic/rfs_pkg.sv ----
/*
  Package for the run and frequency source selector: role codes, selector
  codes, timing constants and widths. Assumes a 50 MHz single clock.
*/
package rfs_pkg;
  localparam int          CLOCK_HZ        = 50000000;
  localparam int          MIN_CLOSE_MS    = 50;
  localparam int          BOTH_ALARM_MS   = 500;
  localparam int          MIN_CLOSE_CYC   = CLOCK_HZ / 1000 * MIN_CLOSE_MS;
  localparam int          BOTH_ALARM_CYC  = CLOCK_HZ / 1000 * BOTH_ALARM_MS;
  localparam int          CNT_W           = 25;
  localparam int          FREQ_W          = 16;
  localparam int          RAMP_W          = 12;
  localparam logic [7:0]  ROLE_THREE_WIRE = 8'h1a;
  localparam logic [7:0]  ROLE_HOLD       = 8'h35;
  localparam logic [7:0]  ROLE_UP         = 8'h08;
  localparam logic [7:0]  ROLE_DOWN       = 8'h09;
  localparam logic [3:0]  INIT_3W_A       = 4'h3;
  localparam logic [3:0]  INIT_3W_B       = 4'h5;
  localparam logic [3:0]  INIT_3W_C       = 4'h7;
  localparam logic [7:0]  ROLE_FWD_RUN    = 8'h00;
  localparam logic [7:0]  ROLE_REV_RUN    = 8'h01;
  localparam logic [7:0]  ROLE_DIR_SEL    = 8'h1b;
  localparam logic [3:0]  AI2_FUNC_ADD    = 4'ha;
  localparam logic [3:0]  AI2_FUNC_AUX    = 4'h0;
  localparam logic [1:0]  PULSE_FUNC_FREQ = 2'h0;
  localparam logic [2:0]  SIG_TYPE_RESET  = 3'h1;
  localparam logic [2:0]  SIG_TYPE_MAX    = 3'h5;
  localparam logic [1:0]  LANG_MAX        = 2'h3;
  localparam logic [1:0]  LANG_RESET      = 2'h0;

  typedef enum logic [2:0] {
    RUN_KEYPAD   = 3'h0,
    RUN_TERMINAL = 3'h1,
    RUN_SERIAL   = 3'h2,
    RUN_LOGIC    = 3'h3,
    RUN_CLOCK    = 3'h4
  } rfs_run_src_e;

  typedef enum logic [3:0] {
    FSRC_KEYPAD   = 4'h0,
    FSRC_ANALOG   = 4'h1,
    FSRC_UPDOWN   = 4'h2,
    FSRC_SERIAL   = 4'h3,
    FSRC_PULSE    = 4'h4,
    FSRC_RESERVED = 4'h5,
    FSRC_CLOCK    = 4'h6,
    FSRC_AUX      = 4'h7,
    FSRC_MANUAL   = 4'h8
  } rfs_freq_src_e;

  typedef enum logic [1:0] {
    WIRE_TWO   = 2'h0,
    WIRE_THREE = 2'h1,
    WIRE_HOLD  = 2'h2
  } rfs_wire_e;
endpackage

// ---- logic/rfs_source_select.sv ----
/*
  Run command and frequency reference source selection for a motor drive.
  Assumes terminals are asynchronous pins; all reference words arrive scaled.
*/
// Behaviour
// - role 26 on terminals three..eight enables three-wire: one runs, two stops
// - init selector 3, 5 or 7 assigns run, stop, direction roles
// - three-wire run closure shorter than 50ms is ignored
// - role 53 on terminals three..eight enables two-wire hold mode
// - hold mode needs terminal five and exactly one of terminals one, two closed 50ms
// - roles 53 and 26 together raise the role conflict error
// - run source 2 serial, 3 builtin logic, 4 real-time clock
// - language accepts 0..3 and survives initialization
// - frequency selectors decode 0..7 except reserved 5; manual pulse 8 on main only
// - keypad: operator entry on main, preset one on alternative
// - analog source uses input one, or input one plus two; signal type 0..5, default 1
// - second analog function 10 adds input two to input one
// - up/down source ramps reference while up or down alone is closed and both roles are assigned
// - pulse input is a reference only when pulse function is 0
// - serial source 3 takes the value written over the serial link
// - clock source 6 takes the real-time-clock reference
// - auxiliary source 7 uses input two if function 0, else zero
// - two-wire: one forward, two reverse, both stop plus alarm after 500ms
// - run source 0 keypad, 1 external terminals
module rfs_source_select (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic [7:0]            terminalPin,
  input  wire logic [2:0]            runSource,
  input  wire logic [7:0]            roleSetting [8],
  input  wire logic                  initWrite,
  input  wire logic [3:0]            initValue,
  input  wire logic                  languageWrite,
  input  wire logic [1:0]            languageValue,
  input  wire logic                  signalTypeWrite,
  input  wire logic [2:0]            signalTypeValue,
  input  wire logic [3:0]            mainSource,
  input  wire logic [3:0]            altSource,
  input  wire logic                  addAlternative,
  input  wire logic [3:0]            ai2Function,
  input  wire logic [1:0]            pulseFunction,
  input  wire logic                  keypadRun,
  input  wire logic                  keypadReverse,
  input  wire logic                  serialRun,
  input  wire logic                  serialReverse,
  input  wire logic                  logicRun,
  input  wire logic                  logicReverse,
  input  wire logic                  clockRun,
  input  wire logic                  clockReverse,
  input  wire logic [15:0]           operatorFreq,
  input  wire logic [15:0]           presetFreqOne,
  input  wire logic [15:0]           analogInputOne,
  input  wire logic [15:0]           analogInputTwo,
  input  wire logic [15:0]           serialFreq,
  input  wire logic [15:0]           pulseFreq,
  input  wire logic [15:0]           clockFreq,
  input  wire logic [15:0]           manualPulseFreq,
  input  wire logic [15:0]           maxFreq,
  output logic                       runCmd,
  output logic                       reverseCmd,
  output logic [15:0]                freqRef,
  output logic                       roleConflictError,
  output logic                       bothDirectionsAlarm,
  output logic                       sourceInvalid,
  output logic [1:0]                 language,
  output logic [2:0]                 signalType,
  output logic [7:0]                 roleOverride [3],
  output logic                       roleOverrideValid
);
  logic [7:0]                closed;
  logic [7:0]                held;
  logic                      anyThree;
  logic                      anyHold;
  logic                      anyUp;
  logic                      anyDown;
  logic                      upClosed;
  logic                      downClosed;
  logic                      latchRun;
  logic                      latchRev;
  logic                      termRun;
  logic                      termRev;
  logic                      next_run;
  logic                      next_rev;
  logic [rfs_pkg::CNT_W-1:0] bothCount;
  logic [15:0]               upDownFreq;
  logic [rfs_pkg::RAMP_W-1:0] rampTick;
  logic [15:0]               mainFreq;
  logic [15:0]               altFreq;
  logic [16:0]               total;
  logic                      mainBad;
  logic                      altBad;
  rfs_pkg::rfs_wire_e        wireMode;

  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gTimer
      rfs_closure_timer #(.LIMIT(rfs_pkg::MIN_CLOSE_CYC)) uTimer (
        .clock  (clock),
        .rst_n  (rst_n),
        .pin    (terminalPin[g]),
        .closed (closed[g]),
        .held   (held[g])
      );
    end
  endgenerate

  function automatic logic roleOnUpper(input logic [7:0] roles [8], input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 2; i < 8; i++) begin
      hit = hit | (roles[i] == code);
    end
    return hit;
  endfunction

  function automatic logic roleAny(input logic [7:0] roles [8], input logic [7:0] code);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      hit = hit | (roles[i] == code);
    end
    return hit;
  endfunction

  // role decode is combinational so any change is rechecked at once
  always_comb begin
    anyThree = roleOnUpper(roleSetting, rfs_pkg::ROLE_THREE_WIRE);
    anyHold  = roleOnUpper(roleSetting, rfs_pkg::ROLE_HOLD);
    anyUp    = roleAny(roleSetting, rfs_pkg::ROLE_UP);
    anyDown  = roleAny(roleSetting, rfs_pkg::ROLE_DOWN);
    upClosed   = 1'b0;
    downClosed = 1'b0;
    for (int i = 0; i < 8; i++) begin
      upClosed   = upClosed | (closed[i] && roleSetting[i] == rfs_pkg::ROLE_UP);
      downClosed = downClosed | (closed[i] && roleSetting[i] == rfs_pkg::ROLE_DOWN);
    end
    if (anyThree && !anyHold) begin
      wireMode = rfs_pkg::WIRE_THREE;
    end else if (anyHold && !anyThree) begin
      wireMode = rfs_pkg::WIRE_HOLD;
    end else begin
      wireMode = rfs_pkg::WIRE_TWO;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      roleConflictError <= 1'b0;
    end else begin
      roleConflictError <= anyThree && anyHold;
    end
  end

  // initialization proposes roles; the role store lives outside
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      roleOverrideValid <= 1'b0;
      roleOverride[0]   <= rfs_pkg::ROLE_FWD_RUN;
      roleOverride[1]   <= rfs_pkg::ROLE_REV_RUN;
      roleOverride[2]   <= rfs_pkg::ROLE_DIR_SEL;
    end else begin
      roleOverrideValid <= initWrite && (initValue == rfs_pkg::INIT_3W_A || initValue == rfs_pkg::INIT_3W_B
                                         || initValue == rfs_pkg::INIT_3W_C);
      roleOverride[0]   <= rfs_pkg::ROLE_FWD_RUN;
      roleOverride[1]   <= rfs_pkg::ROLE_REV_RUN;
      roleOverride[2]   <= rfs_pkg::ROLE_DIR_SEL;
    end
  end

  // language ignores initialization; out-of-range codes are dropped
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      language <= rfs_pkg::LANG_RESET;
    end else if (languageWrite && languageValue <= rfs_pkg::LANG_MAX) begin
      language <= languageValue;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      signalType <= rfs_pkg::SIG_TYPE_RESET;
    end else if (initWrite) begin
      signalType <= rfs_pkg::SIG_TYPE_RESET;
    end else if (signalTypeWrite && signalTypeValue <= rfs_pkg::SIG_TYPE_MAX) begin
      signalType <= signalTypeValue;
    end
  end

  // three-wire: run latches after a held closure, stop (open) clears it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      latchRun <= 1'b0;
      latchRev <= 1'b0;
    end else if (wireMode == rfs_pkg::WIRE_THREE) begin
      latchRev <= closed[6];
      if (!closed[1]) begin
        latchRun <= 1'b0;
      end else if (held[0]) begin
        latchRun <= 1'b1;
      end
    end else if (wireMode == rfs_pkg::WIRE_HOLD) begin
      if (!closed[4] || (!closed[0] && !closed[1])) begin
        latchRun <= 1'b0;
      end else if (held[4] && (held[0] ^ held[1])) begin
        latchRun <= 1'b1;
        latchRev <= held[1];
      end
    end else begin
      latchRun <= 1'b0;
      latchRev <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n || wireMode != rfs_pkg::WIRE_TWO || !(closed[0] && closed[1])) begin
      bothCount           <= '0;
      bothDirectionsAlarm <= 1'b0;
    end else if (bothCount < rfs_pkg::CNT_W'(rfs_pkg::BOTH_ALARM_CYC - 1)) begin
      bothCount <= bothCount + 1'b1;
    end else begin
      bothDirectionsAlarm <= 1'b1;
    end
  end

  always_comb begin
    termRun = latchRun;
    termRev = latchRev;
    if (wireMode == rfs_pkg::WIRE_TWO) begin
      termRun = closed[0] ^ closed[1];
      termRev = closed[1] && !closed[0];
    end
    case (runSource)
      rfs_pkg::RUN_KEYPAD:   begin next_run = keypadRun; next_rev = keypadReverse; end
      rfs_pkg::RUN_TERMINAL: begin next_run = termRun;   next_rev = termRev;       end
      rfs_pkg::RUN_SERIAL:   begin next_run = serialRun; next_rev = serialReverse; end
      rfs_pkg::RUN_LOGIC:    begin next_run = logicRun;  next_rev = logicReverse;  end
      rfs_pkg::RUN_CLOCK:    begin next_run = clockRun;  next_rev = clockReverse;  end
      default:               begin next_run = 1'b0;      next_rev = 1'b0;          end
    endcase
    // raw conflict as well: the flag lags a role change by one cycle
    if (roleConflictError || (anyThree && anyHold)) begin
      next_run = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      runCmd     <= 1'b0;
      reverseCmd <= 1'b0;
    end else begin
      runCmd     <= next_run;
      reverseCmd <= next_rev;
    end
  end

  // up/down ramp: one step per tick; needs both roles assigned
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rampTick   <= '0;
      upDownFreq <= '0;
    end else begin
      rampTick <= rampTick + 1'b1;
      if (rampTick == '1 && anyUp && anyDown) begin
        if (upClosed && !downClosed && upDownFreq < maxFreq) begin
          upDownFreq <= upDownFreq + 1'b1;
        end else if (downClosed && !upClosed && upDownFreq != '0) begin
          upDownFreq <= upDownFreq - 1'b1;
        end
      end
    end
  end

  function automatic logic [15:0] pickFreq(input logic [3:0] src, input logic [15:0] keypadVal, output logic bad);
    logic [16:0] sum;
    sum = {1'b0, analogInputOne} + {1'b0, analogInputTwo};
    bad = 1'b0;
    case (src)
      rfs_pkg::FSRC_KEYPAD: pickFreq = keypadVal;
      rfs_pkg::FSRC_ANALOG: pickFreq = (ai2Function == rfs_pkg::AI2_FUNC_ADD)
                                       ? (sum[16] ? 16'hffff : sum[15:0]) : analogInputOne;
      rfs_pkg::FSRC_UPDOWN: pickFreq = (anyUp && anyDown) ? upDownFreq : 16'h0000;
      rfs_pkg::FSRC_SERIAL: pickFreq = serialFreq;
      rfs_pkg::FSRC_PULSE:  pickFreq = (pulseFunction == rfs_pkg::PULSE_FUNC_FREQ) ? pulseFreq : 16'h0000;
      rfs_pkg::FSRC_CLOCK:  pickFreq = clockFreq;
      rfs_pkg::FSRC_AUX:    pickFreq = (ai2Function == rfs_pkg::AI2_FUNC_AUX) ? analogInputTwo : 16'h0000;
      rfs_pkg::FSRC_MANUAL: pickFreq = manualPulseFreq;
      default: begin
        pickFreq = 16'h0000;
        bad      = 1'b1;
      end
    endcase
  endfunction

  always_comb begin
    mainFreq = pickFreq(mainSource, operatorFreq, mainBad);
    altFreq  = pickFreq(altSource, presetFreqOne, altBad);
    if (altSource == rfs_pkg::FSRC_MANUAL) begin
      altFreq = 16'h0000;
      altBad  = 1'b1;
    end
    total = {1'b0, mainFreq} + (addAlternative ? {1'b0, altFreq} : 17'h00000);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      freqRef       <= '0;
      sourceInvalid <= 1'b0;
    end else begin
      freqRef       <= total[16] ? 16'hffff : total[15:0];
      sourceInvalid <= mainBad || (addAlternative && altBad);
    end
  end
endmodule

// ---- tb/rfs_far_side.sv ----
/*
  Far-side model: run switches on the terminals, the analog sources and the
  serial master's reference word. Assumes the bench operates the switches.
*/
module rfs_far_side #(
  parameter logic [15:0] AI1 = 16'h0123,
  parameter logic [15:0] AI2 = 16'h0456,
  parameter logic [15:0] SER = 16'h0789,
  parameter logic [15:0] PUL = 16'h0abc
) (
  input  wire logic [7:0]  switches,
  output logic      [7:0]  terminalPin,
  output logic      [15:0] analogInputOne,
  output logic      [15:0] analogInputTwo,
  output logic      [15:0] serialFreq,
  output logic      [15:0] pulseFreq
);
  timeunit 1ns;
  timeprecision 1ps;
  // bounce-free contacts; how long one stays closed is up to the operator
  assign terminalPin    = switches;
  assign analogInputOne = AI1;
  assign analogInputTwo = AI2;
  assign serialFreq     = SER;
  assign pulseFreq      = PUL;
endmodule

// ---- tb/rfs_source_select_asserts.sv ----
/*
  Checker for the source selector: role conflict, setting writes, init pulse
  and reference choice. Assumes one clock and a synchronous low reset.
*/
module rfs_source_select_asserts (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [7:0]  roleSetting [8],
  input wire logic        initWrite,
  input wire logic [3:0]  initValue,
  input wire logic        languageWrite,
  input wire logic [1:0]  languageValue,
  input wire logic        signalTypeWrite,
  input wire logic [2:0]  signalTypeValue,
  input wire logic [3:0]  mainSource,
  input wire logic [3:0]  altSource,
  input wire logic        addAlternative,
  input wire logic [3:0]  ai2Function,
  input wire logic [15:0] operatorFreq,
  input wire logic [15:0] analogInputTwo,
  input wire logic [15:0] serialFreq,
  input wire logic [15:0] clockFreq,
  input wire logic [15:0] manualPulseFreq,
  input wire logic        runCmd,
  input wire logic [15:0] freqRef,
  input wire logic        roleConflictError,
  input wire logic        sourceInvalid,
  input wire logic [1:0]  language,
  input wire logic [2:0]  signalType,
  input wire logic        roleOverrideValid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic        hasThree;
  logic        hasHold;
  logic        conflict;
  logic        initHit;
  logic        badSrc;
  logic [15:0] direct;
  // only terminals three..eight select a wiring mode
  always_comb begin
    hasThree = 1'b0;
    hasHold  = 1'b0;
    for (int i = 2; i < 8; i++) begin
      hasThree |= roleSetting[i] == rfs_pkg::ROLE_THREE_WIRE;
      hasHold  |= roleSetting[i] == rfs_pkg::ROLE_HOLD;
    end
  end
  always_comb begin
    case (mainSource)
      4'h0: direct = operatorFreq;
      4'h3: direct = serialFreq;
      4'h6: direct = clockFreq;
      default: direct = manualPulseFreq;
    endcase
  end
  assign conflict = hasThree && hasHold;
  assign initHit  = initWrite && (initValue inside {rfs_pkg::INIT_3W_A, rfs_pkg::INIT_3W_B, rfs_pkg::INIT_3W_C});
  assign badSrc   = mainSource == 4'h5 || mainSource > 4'h8 || (addAlternative && (altSource == 4'h5 || altSource >= 4'h8));
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  a_conflict_flag: assert property ($past(rst_n) |-> roleConflictError == $past(conflict))
    else $error("role conflict flag does not follow the role settings");
  a_conflict_stop: assert property (roleConflictError |-> !runCmd)
    else $error("run command active during a role conflict");
  a_lang_write: assert property (languageWrite |=> language == $past(languageValue))
    else $error("language write not taken");
  a_lang_keep: assert property (initWrite && !languageWrite |=> $stable(language))
    else $error("language changed by initialization");
  a_type_write: assert property (signalTypeWrite && !initWrite && signalTypeValue <= rfs_pkg::SIG_TYPE_MAX
    |=> signalType == $past(signalTypeValue))
    else $error("signal type write not taken");
  a_type_refuse: assert property (signalTypeWrite && !initWrite && signalTypeValue > rfs_pkg::SIG_TYPE_MAX
    |=> $stable(signalType))
    else $error("signal type out of range accepted");
  a_type_init: assert property (initHit && !signalTypeWrite |=> signalType == rfs_pkg::SIG_TYPE_RESET)
    else $error("signal type not restored by initialization");
  a_override_pulse: assert property ($past(rst_n) |-> roleOverrideValid == $past(initHit))
    else $error("role override pulse wrong");
  a_main_direct: assert property (!addAlternative && (mainSource inside {4'h0, 4'h3, 4'h6, 4'h8})
    |=> freqRef == $past(direct))
    else $error("reference does not follow the main source");
  a_aux_input: assert property (!addAlternative && mainSource == 4'h7 |=> freqRef ==
    ($past(ai2Function) == rfs_pkg::AI2_FUNC_AUX ? $past(analogInputTwo) : 16'h0000))
    else $error("auxiliary reference wrong");
  a_bad_source: assert property ($past(rst_n) |-> sourceInvalid == $past(badSrc))
    else $error("source invalid flag wrong");
  c_conflict: cover property (roleConflictError);
  c_override: cover property (roleOverrideValid);
  c_invalid: cover property (sourceInvalid);
endmodule

bind rfs_source_select rfs_source_select_asserts u_rfs_source_select_asserts (
  .clock(clock), .rst_n(rst_n), .roleSetting(roleSetting), .initWrite(initWrite), .initValue(initValue),
  .languageWrite(languageWrite), .languageValue(languageValue), .signalTypeWrite(signalTypeWrite),
  .signalTypeValue(signalTypeValue), .mainSource(mainSource), .altSource(altSource),
  .addAlternative(addAlternative), .ai2Function(ai2Function), .operatorFreq(operatorFreq),
  .analogInputTwo(analogInputTwo), .serialFreq(serialFreq), .clockFreq(clockFreq),
  .manualPulseFreq(manualPulseFreq), .runCmd(runCmd), .freqRef(freqRef), .roleConflictError(roleConflictError),
  .sourceInvalid(sourceInvalid), .language(language), .signalType(signalType),
  .roleOverrideValid(roleOverrideValid)
);

// ---- tb/tb_rfs_source_select.sv ----
/*
  Bench for the source selector: run modes, setting writes, initialization
  and reference sources. Assumes the far-side model feeds terminals and words.
*/
module tb_rfs_source_select;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] AI1 = 16'h0123, AI2 = 16'h0456, SER = 16'h0789, PUL = 16'h0abc;
  localparam logic [15:0] RTC = 16'h0def, MANUAL_PULSE_GENERATOR = 16'h0321, OPF = 16'h0111, PRE = 16'h0222;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [7:0]  switches = 8'h00;
  logic [7:0]  cmdBits = 8'h00;
  logic [7:0]  sel;
  logic [7:0]  roleSetting [8] = '{0: 8'h00, 1: 8'h01, default: 8'h10};
  logic [2:0]  runSource = 3'h1;
  logic [2:0]  signalTypeValue = 3'h0;
  logic [3:0]  initValue = 4'h0, mainSource = 4'h0, altSource = 4'h0, ai2Function = 4'h0;
  logic [1:0]  languageValue = 2'h0, pulseFunction = 2'h0;
  logic        initWrite = 1'b0, languageWrite = 1'b0, signalTypeWrite = 1'b0, addAlternative = 1'b0;
  logic [7:0]  terminalPin;
  logic [15:0] analogInputOne, analogInputTwo, serialFreq, pulseFreq, freqRef, base;
  logic        runCmd, reverseCmd, roleConflictError, bothDirectionsAlarm, sourceInvalid, roleOverrideValid;
  logic [1:0]  language;
  logic [2:0]  signalType;
  logic [7:0]  roleOverride [3];
  logic [3:0]  srcTab [5] = '{4'h0, 4'h3, 4'h6, 4'h8, 4'h4};
  logic [15:0] expTab [5] = '{OPF, SER, RTC, MANUAL_PULSE_GENERATOR, PUL};
  int          fails = 0, n_checks = 0;

  always #10 clock = ~clock;

  rfs_far_side #(.AI1(AI1), .AI2(AI2), .SER(SER), .PUL(PUL)) u_rfs_far_side (
    .switches(switches), .terminalPin(terminalPin), .analogInputOne(analogInputOne),
    .analogInputTwo(analogInputTwo), .serialFreq(serialFreq), .pulseFreq(pulseFreq));

  rfs_source_select u_rfs_source_select (
    .clock(clock), .rst_n(rst_n), .terminalPin(terminalPin), .runSource(runSource),
    .roleSetting(roleSetting), .initWrite(initWrite), .initValue(initValue), .languageWrite(languageWrite),
    .languageValue(languageValue), .signalTypeWrite(signalTypeWrite), .signalTypeValue(signalTypeValue),
    .mainSource(mainSource), .altSource(altSource), .addAlternative(addAlternative), .ai2Function(ai2Function),
    .pulseFunction(pulseFunction), .keypadRun(cmdBits[0]), .keypadReverse(cmdBits[1]),
    .serialRun(cmdBits[2]), .serialReverse(cmdBits[3]), .logicRun(cmdBits[4]), .logicReverse(cmdBits[5]),
    .clockRun(cmdBits[6]), .clockReverse(cmdBits[7]), .operatorFreq(OPF), .presetFreqOne(PRE),
    .analogInputOne(analogInputOne), .analogInputTwo(analogInputTwo), .serialFreq(serialFreq),
    .pulseFreq(pulseFreq), .clockFreq(RTC), .manualPulseFreq(MANUAL_PULSE_GENERATOR), .maxFreq(16'h1000), .runCmd(runCmd),
    .reverseCmd(reverseCmd), .freqRef(freqRef), .roleConflictError(roleConflictError),
    .bothDirectionsAlarm(bothDirectionsAlarm), .sourceInvalid(sourceInvalid), .language(language),
    .signalType(signalType), .roleOverride(roleOverride), .roleOverrideValid(roleOverrideValid));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic sw(input logic [7:0] v);
    @(posedge clock);
    switches <= v;
  endtask
  // six cycles covers the two-stage pin synchroniser plus the output register
  task automatic runIs(input logic [1:0] exp);
    tick(6);
    @(negedge clock);
    chk({runCmd, reverseCmd}, exp);
  endtask
  task automatic freq(input logic [3:0] m, input logic [15:0] exp);
    @(posedge clock);
    mainSource <= m;
    tick(3);
    @(negedge clock);
    chk(freqRef, exp);
  endtask
  task automatic initPulse(input logic [3:0] v);
    @(posedge clock);
    initWrite <= 1'b1;
    initValue <= v;
    @(posedge clock);
    initWrite <= 1'b0;
    @(negedge clock);
    chk(roleOverrideValid, v inside {4'h3, 4'h5, 4'h7});
  endtask
  task automatic setWr(input logic lang, input logic [2:0] v);
    @(posedge clock);
    languageWrite <= lang;
    signalTypeWrite <= !lang;
    languageValue <= v[1:0];
    signalTypeValue <= v;
    @(posedge clock);
    languageWrite <= 1'b0;
    signalTypeWrite <= 1'b0;
    @(negedge clock);
  endtask
  task automatic end_of_test;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    tick(40000);
    fails++;
    end_of_test();
  end

  initial begin
    tick(3);
    rst_n <= 1'b1;
    @(negedge clock);
    chk(language, rfs_pkg::LANG_RESET);
    chk(signalType, rfs_pkg::SIG_TYPE_RESET);
    sw(8'h01);
    runIs(2'b10);
    sw(8'h02);
    runIs(2'b11);
    sw(8'h03);
    tick(6);
    @(negedge clock);
    chk(runCmd, 1'b0);
    chk(bothDirectionsAlarm, 1'b0);
    sw(8'h00);
    runIs(2'b00);
    for (int s = 0; s < 5; s++) begin
      if (s != 1) begin
        sel = 8'h03 << (2 * (s == 0 ? 0 : s - 1));
        @(posedge clock);
        runSource <= 3'(s);
        cmdBits <= ~sel;
        runIs(2'b00);
        @(posedge clock);
        cmdBits <= sel;
        runIs(2'b11);
      end
    end
    @(posedge clock);
    runSource <= 3'h5;
    runIs(2'b00);
    @(posedge clock);
    runSource <= 3'h1;
    cmdBits <= 8'h00;
    roleSetting[2] <= rfs_pkg::ROLE_THREE_WIRE;
    // run pressed with stop closed, but far shorter than the minimum closure
    sw(8'h03);
    runIs(2'b00);
    sw(8'h00);
    @(posedge clock);
    roleSetting[2] <= rfs_pkg::ROLE_HOLD;
    sw(8'h11);
    runIs(2'b00);
    @(posedge clock);
    roleSetting[7] <= rfs_pkg::ROLE_THREE_WIRE;
    runIs(2'b00);
    chk(roleConflictError, 1'b1);
    @(posedge clock);
    roleSetting[2] <= 8'h10;
    runIs(2'b00);
    chk(roleConflictError, 1'b0);
    @(posedge clock);
    roleSetting[7] <= 8'h10;
    sw(8'h00);
    setWr(1'b1, 3'h3);
    chk(language, 2'h3);
    setWr(1'b0, 3'h5);
    chk(signalType, 3'h5);
    setWr(1'b0, 3'h6);
    chk(signalType, 3'h5);
    for (int v = 0; v < 8; v++)
      initPulse(4'(v));
    chk(signalType, rfs_pkg::SIG_TYPE_RESET);
    chk(language, 2'h3);
    chk(roleOverride[0], rfs_pkg::ROLE_FWD_RUN);
    chk(roleOverride[1], rfs_pkg::ROLE_REV_RUN);
    chk(roleOverride[2], rfs_pkg::ROLE_DIR_SEL);
    for (int i = 0; i < 5; i++)
      freq(srcTab[i], expTab[i]);
    chk(sourceInvalid, 1'b0);
    freq(4'h1, AI1);
    @(posedge clock);
    ai2Function <= rfs_pkg::AI2_FUNC_ADD;
    freq(4'h1, AI1 + AI2);
    freq(4'h7, 16'h0000);
    @(posedge clock);
    ai2Function <= rfs_pkg::AI2_FUNC_AUX;
    freq(4'h7, AI2);
    @(posedge clock);
    addAlternative <= 1'b1;
    freq(4'h3, SER + PRE);
    @(posedge clock);
    altSource <= 4'h8;
    tick(3);
    @(negedge clock);
    chk(sourceInvalid, 1'b1);
    @(posedge clock);
    addAlternative <= 1'b0;
    mainSource <= 4'h2;
    // up role alone: the ramp must stay idle until down is assigned too
    roleSetting[2] <= rfs_pkg::ROLE_UP;
    tick(5);
    @(negedge clock);
    base = freqRef;
    sw(8'h04);
    tick(9000);
    @(negedge clock);
    chk(freqRef, base);
    @(posedge clock);
    roleSetting[3] <= rfs_pkg::ROLE_DOWN;
    tick(9000);
    @(negedge clock);
    chk(freqRef > base, 1'b1);
    base = freqRef;
    sw(8'h08);
    tick(9000);
    @(negedge clock);
    chk(freqRef < base, 1'b1);
    end_of_test();
  end
endmodule
